//--- logic/dos_consts.vh
`ifndef DOS_CONSTS_VH
`define DOS_CONSTS_VH

// ****************************************************************
// clock and time base
// ****************************************************************
`define DOS_CLK_HZ            200000000
`define DOS_TICK_NS           10000000
// last prescaler count of a 10 ms tick, the unit of all delay settings
`define DOS_TICK_LAST         21'h1E847F

// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define DOS_A_CTRL            8'h00
`define DOS_A_ASSERT_DLY      8'h04
`define DOS_A_DEASSERT_DLY    8'h08
`define DOS_A_REL_CURR        8'h0C
`define DOS_A_REL_HOLD        8'h10
`define DOS_A_REL_FWD         8'h14
`define DOS_A_REL_REV         8'h18
`define DOS_A_ENG_HOLD        8'h1C
`define DOS_A_ENG_FREQ        8'h20
`define DOS_A_ONOFF_SRC       8'h24
`define DOS_A_ON_LVL          8'h28
`define DOS_A_OFF_LVL         8'h2C
`define DOS_A_STATUS          8'h30

// ****************************************************************
// ctrl fields
// ****************************************************************
`define DOS_CTRL_RELAY_LO     0
`define DOS_CTRL_RELAY_HI     1
`define DOS_CTRL_OC_LO        2
`define DOS_CTRL_OC_HI        3
`define DOS_CTRL_MODE_LO      4
`define DOS_CTRL_MODE_HI      5
`define DOS_CTRL_DCB          6
`define DOS_CTRL_RST          32'h00000000

// output source codes
`define DOS_SRC_NONE          2'h0
`define DOS_SRC_TIMER         2'h1
`define DOS_SRC_BRAKE         2'h2
`define DOS_SRC_ONOFF         2'h3

// control modes
`define DOS_MODE_VF           2'h0

// ****************************************************************
// reset values: delays in 10 ms ticks, freq in 0.01 Hz, levels in 0.01 %
// ****************************************************************
`define DOS_ASSERT_DLY_RST    16'h012C
`define DOS_DEASSERT_DLY_RST  16'h0064
`define DOS_DLY_MAX           16'h2710
`define DOS_HOLD_MAX          16'h03E8
`define DOS_REL_CURR_RST      16'h1388
`define DOS_REL_HOLD_RST      16'h0064
`define DOS_REL_FREQ_RST      16'h0064
`define DOS_ENG_HOLD_RST      16'h0064
`define DOS_ENG_FREQ_RST      16'h00C8
`define DOS_SRC_VOLT_ONE      2'h1
`define DOS_ON_LVL_RST        16'h2328
`define DOS_OFF_LVL_RST       16'h03E8
`define DOS_ON_LVL_MIN        16'h03E8
`define DOS_ON_LVL_MAX        16'h2710

`endif

//--- logic/dos_delay_timer.v
`include "dos_consts.vh"

// ****************************************************************
// on/off delayed follower of one input level
// ****************************************************************
module dos_delay_timer (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        tick_i,
    input  wire        in_i,
    input  wire [15:0] on_dly_i,
    input  wire [15:0] off_dly_i,
    output reg         out_o
);
    reg [15:0] cnt_reg;

    // count ticks while input differs from output; restart on any bounce
    always @(posedge clk_i) begin
        if (rst_i) begin
            cnt_reg <= 16'h0000;
            out_o   <= 1'b0;
        end else if (in_i == out_o) begin
            cnt_reg <= 16'h0000;
        end else if (in_i && cnt_reg >= on_dly_i) begin
            out_o   <= 1'b1;
            cnt_reg <= 16'h0000;
        end else if (!in_i && cnt_reg >= off_dly_i) begin
            out_o   <= 1'b0;
            cnt_reg <= 16'h0000;
        end else if (tick_i) begin
            cnt_reg <= cnt_reg + 16'h0001;
        end
    end
endmodule

//--- logic/dos_hyst_comp.v
`include "dos_consts.vh"

// ****************************************************************
// hysteresis comparator with separate on and off levels
// ****************************************************************
module dos_hyst_comp (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire [15:0] value_i,
    input  wire [15:0] on_lvl_i,
    input  wire [15:0] off_lvl_i,
    output reg         out_o
);
    // between the levels the output keeps its state
    always @(posedge clk_i) begin
        if (rst_i) begin
            out_o <= 1'b0;
        end else if (value_i > on_lvl_i) begin
            out_o <= 1'b1;
        end else if (value_i < off_lvl_i) begin
            out_o <= 1'b0;
        end
    end
endmodule

//--- logic/dos_top.v
// Chosen here: the register addresses and register access over Wishbone.
`include "dos_consts.vh"

module dos_top (
    input  wire        clk_i,
    input  wire        rst_i,
    // wishbone classic slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    // drive side
    input  wire [6:0]  timer_in_i,
    input  wire [6:0]  timer_in_en_i,
    input  wire        run_i,
    input  wire        reverse_i,
    input  wire [15:0] motor_current_i,
    input  wire [15:0] out_freq_i,
    input  wire [15:0] voltage_input_one_i,
    input  wire [15:0] analog_v2_i,
    input  wire [15:0] analog_i1_i,
    output reg         relay_o,
    output reg         oc_out_o,
    output reg         freq_ramp_o,
    output reg         freq_hold_o,
    output reg         freq_zero_o,
    output reg  [15:0] freq_target_o,
    output reg         dc_brake_o,
    output reg         output_cut_o,
    output reg         start_dc_dwell_inhibit_o
);
    // ****************************************************************
    // registers
    // ****************************************************************
    reg [31:0] ctrl_reg;
    reg [15:0] assert_delay_reg;
    reg [15:0] deassert_delay_reg;
    reg [15:0] release_current_threshold_reg;
    reg [15:0] release_hold_time_reg;
    reg [15:0] release_freq_forward_reg;
    reg [15:0] release_freq_reverse_reg;
    reg [15:0] engage_hold_time_reg;
    reg [15:0] engage_frequency_reg;
    reg [1:0]  onoff_src_reg;
    reg [15:0] on_level_reg;
    reg [15:0] off_level_reg;
    reg [20:0] tick_cnt_reg;
    reg        tick_reg;
    reg [15:0] hold_cnt_reg;
    reg [6:0]  bstate_reg;
    reg [6:0]  bstate_next;
    reg [15:0] analog_sel;
    reg [31:0] rd_data;

    wire       timer_out;
    wire       onoff_out;
    wire       wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire [1:0] relay_src = ctrl_reg[`DOS_CTRL_RELAY_HI:`DOS_CTRL_RELAY_LO];
    wire [1:0] oc_src    = ctrl_reg[`DOS_CTRL_OC_HI:`DOS_CTRL_OC_LO];
    wire [1:0] ctl_mode  = ctrl_reg[`DOS_CTRL_MODE_HI:`DOS_CTRL_MODE_LO];
    wire       brake_used = (relay_src == `DOS_SRC_BRAKE) | (oc_src == `DOS_SRC_BRAKE);
    wire       timer_in_act = |(timer_in_i & timer_in_en_i);

    // brake states, one-hot
    localparam [6:0] ST_IDLE  = 7'h01;
    localparam [6:0] ST_ACCEL = 7'h02;
    localparam [6:0] ST_RHOLD = 7'h04;
    localparam [6:0] ST_RUN   = 7'h08;
    localparam [6:0] ST_DECEL = 7'h10;
    localparam [6:0] ST_EHOLD = 7'h20;
    localparam [6:0] ST_DCB   = 7'h40;

    // ****************************************************************
    // 10 ms tick
    // ****************************************************************
    // all delays share one prescaler so each timer stays a 16-bit count
    always @(posedge clk_i) begin
        if (rst_i || tick_cnt_reg == `DOS_TICK_LAST) begin
            tick_cnt_reg <= 21'h00000;
            tick_reg     <= ~rst_i;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 21'h00001;
            tick_reg     <= 1'b0;
        end
    end

    // ****************************************************************
    // wishbone register file
    // ****************************************************************
    // write clamps keep delays and levels inside their legal ranges
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o                      <= 1'b0;
            wb_dat_o                      <= 32'h00000000;
            ctrl_reg                      <= `DOS_CTRL_RST;
            assert_delay_reg              <= `DOS_ASSERT_DLY_RST;
            deassert_delay_reg            <= `DOS_DEASSERT_DLY_RST;
            release_current_threshold_reg <= `DOS_REL_CURR_RST;
            release_hold_time_reg         <= `DOS_REL_HOLD_RST;
            release_freq_forward_reg      <= `DOS_REL_FREQ_RST;
            release_freq_reverse_reg      <= `DOS_REL_FREQ_RST;
            engage_hold_time_reg          <= `DOS_ENG_HOLD_RST;
            engage_frequency_reg          <= `DOS_ENG_FREQ_RST;
            onoff_src_reg                 <= `DOS_SRC_VOLT_ONE;
            on_level_reg                  <= `DOS_ON_LVL_RST;
            off_level_reg                 <= `DOS_OFF_LVL_RST;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= wb_req ? rd_data : 32'h00000000;
            // a write lands on the edge at which the master sees ack
            if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && (&wb_sel_i[1:0])) begin
                case (wb_adr_i)
                    `DOS_A_CTRL:
                        ctrl_reg <= {25'h0000000, wb_dat_i[6:0]};
                    `DOS_A_ASSERT_DLY:
                        assert_delay_reg <= (wb_dat_i[15:0] > `DOS_DLY_MAX) ?
                                            `DOS_DLY_MAX : wb_dat_i[15:0];
                    `DOS_A_DEASSERT_DLY:
                        deassert_delay_reg <= (wb_dat_i[15:0] > `DOS_DLY_MAX) ?
                                              `DOS_DLY_MAX : wb_dat_i[15:0];
                    `DOS_A_REL_CURR: release_current_threshold_reg <= wb_dat_i[15:0];
                    `DOS_A_REL_HOLD:
                        release_hold_time_reg <= (wb_dat_i[15:0] > `DOS_HOLD_MAX) ?
                                                 `DOS_HOLD_MAX : wb_dat_i[15:0];
                    `DOS_A_REL_FWD:  release_freq_forward_reg <= wb_dat_i[15:0];
                    `DOS_A_REL_REV:  release_freq_reverse_reg <= wb_dat_i[15:0];
                    `DOS_A_ENG_HOLD:
                        engage_hold_time_reg <= (wb_dat_i[15:0] > `DOS_HOLD_MAX) ?
                                                `DOS_HOLD_MAX : wb_dat_i[15:0];
                    `DOS_A_ENG_FREQ: engage_frequency_reg <= wb_dat_i[15:0];
                    `DOS_A_ONOFF_SRC: onoff_src_reg <= wb_dat_i[1:0];
                    `DOS_A_ON_LVL: begin
                        if (wb_dat_i[15:0] < `DOS_ON_LVL_MIN)
                            on_level_reg <= `DOS_ON_LVL_MIN;
                        else if (wb_dat_i[15:0] > `DOS_ON_LVL_MAX)
                            on_level_reg <= `DOS_ON_LVL_MAX;
                        else
                            on_level_reg <= wb_dat_i[15:0];
                    end
                    `DOS_A_OFF_LVL:
                        off_level_reg <= (wb_dat_i[15:0] > on_level_reg) ?
                                         on_level_reg : wb_dat_i[15:0];
                    default: ;
                endcase
            end
        end
    end

    // read mux; unmapped addresses read zero and still ack
    always @* begin
        case (wb_adr_i)
            `DOS_A_CTRL:         rd_data = ctrl_reg;
            `DOS_A_ASSERT_DLY:   rd_data = {16'h0000, assert_delay_reg};
            `DOS_A_DEASSERT_DLY: rd_data = {16'h0000, deassert_delay_reg};
            `DOS_A_REL_CURR:     rd_data = {16'h0000, release_current_threshold_reg};
            `DOS_A_REL_HOLD:     rd_data = {16'h0000, release_hold_time_reg};
            `DOS_A_REL_FWD:      rd_data = {16'h0000, release_freq_forward_reg};
            `DOS_A_REL_REV:      rd_data = {16'h0000, release_freq_reverse_reg};
            `DOS_A_ENG_HOLD:     rd_data = {16'h0000, engage_hold_time_reg};
            `DOS_A_ENG_FREQ:     rd_data = {16'h0000, engage_frequency_reg};
            `DOS_A_ONOFF_SRC:    rd_data = {30'h00000000, onoff_src_reg};
            `DOS_A_ON_LVL:       rd_data = {16'h0000, on_level_reg};
            `DOS_A_OFF_LVL:      rd_data = {16'h0000, off_level_reg};
            `DOS_A_STATUS:       rd_data = {20'h00000, 1'b0, bstate_reg,
                                            timer_out, onoff_out, relay_o, oc_out_o};
            default:             rd_data = 32'h00000000;
        endcase
    end

    // ****************************************************************
    // timer and on/off sources
    // ****************************************************************
    dos_delay_timer u_timer (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .tick_i    (tick_reg),
        .in_i      (timer_in_act),
        .on_dly_i  (assert_delay_reg),
        .off_dly_i (deassert_delay_reg),
        .out_o     (timer_out)
    );

    // analog source select: 1 = voltage one, 2 = voltage two, 3 = current
    always @* begin
        case (onoff_src_reg)
            2'h1:    analog_sel = voltage_input_one_i;
            2'h2:    analog_sel = analog_v2_i;
            2'h3:    analog_sel = analog_i1_i;
            default: analog_sel = 16'h0000;
        endcase
    end

    dos_hyst_comp u_comp (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .value_i   (analog_sel),
        .on_lvl_i  (on_level_reg),
        .off_lvl_i (off_level_reg),
        .out_o     (onoff_out)
    );

    // ****************************************************************
    // brake sequencer
    // ****************************************************************
    wire [15:0] rel_freq = reverse_i ? release_freq_reverse_reg : release_freq_forward_reg;
    wire        hold_done = tick_reg && (hold_cnt_reg >=
                    (bstate_reg == ST_RHOLD ? release_hold_time_reg : engage_hold_time_reg));
    // only v/f mode waits on current; vector modes trust the torque loop
    wire        cur_ok = (ctl_mode != `DOS_MODE_VF) ||
                         (motor_current_i >= release_current_threshold_reg);

    always @* begin
        bstate_next = bstate_reg;
        case (bstate_reg)
            ST_IDLE:  if (run_i && brake_used) bstate_next = ST_ACCEL;
            ST_ACCEL: if (!run_i) bstate_next = ST_IDLE;
                      else if (out_freq_i >= rel_freq && cur_ok)
                          bstate_next = ST_RHOLD;
            ST_RHOLD: if (hold_done) bstate_next = ST_RUN;
            ST_RUN:   if (!run_i) bstate_next = ST_DECEL;
            ST_DECEL: if (out_freq_i <= engage_frequency_reg)
                          bstate_next = ST_EHOLD;
            ST_EHOLD: if (hold_done)
                          bstate_next = ctrl_reg[`DOS_CTRL_DCB] ? ST_DCB : ST_IDLE;
            ST_DCB:   if (!run_i && !ctrl_reg[`DOS_CTRL_DCB]) bstate_next = ST_IDLE;
                      else if (run_i) bstate_next = ST_IDLE;
            default:  bstate_next = ST_IDLE;
        endcase
    end

    // state, hold counter and all registered drive outputs
    always @(posedge clk_i) begin
        if (rst_i) begin
            bstate_reg               <= ST_IDLE;
            hold_cnt_reg             <= 16'h0000;
            relay_o                  <= 1'b0;
            oc_out_o                 <= 1'b0;
            freq_ramp_o              <= 1'b0;
            freq_hold_o              <= 1'b0;
            freq_zero_o              <= 1'b1;
            freq_target_o            <= 16'h0000;
            dc_brake_o               <= 1'b0;
            output_cut_o             <= 1'b0;
            start_dc_dwell_inhibit_o <= 1'b0;
        end else begin
            bstate_reg <= bstate_next;
            if (bstate_next != bstate_reg)
                hold_cnt_reg <= 16'h0000;
            else if (tick_reg)
                hold_cnt_reg <= hold_cnt_reg + 16'h0001;
            start_dc_dwell_inhibit_o <= brake_used;
            freq_hold_o   <= (bstate_next == ST_RHOLD) | (bstate_next == ST_EHOLD);
            freq_ramp_o   <= (bstate_next == ST_ACCEL) | (bstate_next == ST_RUN) |
                             (bstate_next == ST_DECEL);
            freq_target_o <= (bstate_next == ST_ACCEL) ? rel_freq :
                             (bstate_next == ST_DECEL) ? engage_frequency_reg : 16'h0000;
            freq_zero_o   <= (bstate_next == ST_IDLE) | (bstate_next == ST_DCB);
            dc_brake_o    <= (bstate_next == ST_DCB);
            output_cut_o  <= (bstate_reg == ST_DCB) & (bstate_next == ST_IDLE);
            relay_o  <= (relay_src == `DOS_SRC_TIMER) ? timer_out :
                        (relay_src == `DOS_SRC_ONOFF) ? onoff_out :
                        (relay_src == `DOS_SRC_BRAKE) ?
                            ((bstate_next == ST_RHOLD) | (bstate_next == ST_RUN) |
                             (bstate_next == ST_DECEL)) : 1'b0;
            oc_out_o <= (oc_src == `DOS_SRC_TIMER) ? timer_out :
                        (oc_src == `DOS_SRC_ONOFF) ? onoff_out :
                        (oc_src == `DOS_SRC_BRAKE) ?
                            ((bstate_next == ST_RHOLD) | (bstate_next == ST_RUN) |
                             (bstate_next == ST_DECEL)) : 1'b0;
        end
    end
endmodule

//--- tb/dos_plant.sv
// ****************************************************************
// motor stand-in: output frequency follows the ramp requests
// ****************************************************************
module dos_plant (
    input  wire        clk_i,
    input  wire        ramp_i,
    input  wire        hold_i,
    input  wire        zero_i,
    input  wire [15:0] target_i,
    output reg  [15:0] freq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial freq_o = 16'h0000;
    // one 0.01 Hz step a cycle keeps ramps short; target 0 leaves the frequency where it is
    always @(posedge clk_i) begin
        if (zero_i) begin
            freq_o <= 16'h0000;
        end else if (ramp_i && !hold_i && target_i != 16'h0000 && freq_o != target_i) begin
            freq_o <= freq_o < target_i ? freq_o + 16'h0001 : freq_o - 16'h0001;
        end
    end
endmodule

//--- tb/dos_top_sva.sv
module dos_top_sva (
    input wire        clk_i,
    input wire        rst_i,
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire        wb_we_i,
    input wire [7:0]  wb_adr_i,
    input wire [3:0]  wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire        wb_ack_o,
    input wire        run_i,
    input wire [15:0] motor_current_i,
    input wire [15:0] voltage_input_one_i,
    input wire [15:0] analog_v2_i,
    input wire [15:0] analog_i1_i,
    input wire        relay_o,
    input wire        oc_out_o,
    input wire        freq_zero_o,
    input wire        start_dc_dwell_inhibit_o
);
    timeunit 1ns;
    timeprecision 1ps;
    reg  [6:0]  cs;
    reg  [1:0]  asrc;
    reg  [15:0] cur_s;
    reg  [15:0] on_s;
    reg  [15:0] off_s;
    wire [15:0] d = wb_dat_i[15:0];
    wire        wr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[1:0] == 2'h3;
    wire [15:0] on_w = d < 16'h03E8 ? 16'h03E8 : (d > 16'h2710 ? 16'h2710 : d);
    wire [15:0] aval = asrc == 2'h1 ? voltage_input_one_i :
                       (asrc == 2'h2 ? analog_v2_i : analog_i1_i);
    wire        onoff = cs[3:2] == 2'h3 && asrc != 2'h0;
    wire        rbrake = cs[1:0] == 2'h2 && cs[5:4] == 2'h0;
    wire        hasbr = cs[1:0] == 2'h2 || cs[3:2] == 2'h2;
    // ****************************************************************
    // shadow of the settings, taken on the same edge the slave takes them
    // ****************************************************************
    always @(posedge clk_i) begin
        if (rst_i) begin
            cs    <= 7'h00;
            asrc  <= 2'h1;
            cur_s <= 16'h1388;
            on_s  <= 16'h2328;
            off_s <= 16'h03E8;
        end else if (wr) begin
            case (wb_adr_i)
                8'h00: cs <= wb_dat_i[6:0];
                8'h0C: cur_s <= d;
                8'h24: asrc <= wb_dat_i[1:0];
                8'h28: on_s <= on_w;
                8'h2C: off_s <= d > on_s ? on_s : d;
                default: ;
            endcase
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    // the latency of the output path may be one or two stages, so both are allowed
    sequence s_rel;
        $rose(relay_o) && $past(rbrake, 2);
    endsequence
    a_reset_clears: assert property (disable iff (1'b0) rst_i |=>
        !relay_o && !oc_out_o && freq_zero_o && !wb_ack_o) else $error("outputs not cleared");
    a_ack_next: assert property (s_req |=> wb_ack_o) else $error("no ack");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_inhibit_on: assert property (hasbr [*3] |-> start_dc_dwell_inhibit_o)
        else $error("start dc not inhibited");
    a_inhibit_off: assert property (!hasbr [*3] |-> !start_dc_dwell_inhibit_o)
        else $error("start dc inhibited");
    a_release_current: assert property (s_rel |-> $past(run_i) &&
        ($past(motor_current_i) >= $past(cur_s) || $past(motor_current_i, 2) >= $past(cur_s, 2)))
        else $error("release below current");
    a_onoff_rise: assert property ($rose(oc_out_o) && $past(onoff, 2) |->
        $past(aval) > $past(on_s) || $past(aval, 2) > $past(on_s, 2)) else $error("bad on");
    a_onoff_fall: assert property ($fell(oc_out_o) && $past(onoff, 2) |->
        $past(aval) < $past(off_s) || $past(aval, 2) < $past(off_s, 2)) else $error("bad off");
    a_onoff_hold: assert property ($past(onoff) && $past(onoff, 2) && onoff &&
        $past(aval) <= $past(on_s) && $past(aval) >= $past(off_s) &&
        $past(aval, 2) <= $past(on_s, 2) && $past(aval, 2) >= $past(off_s, 2)
        |-> $stable(oc_out_o)) else $error("onoff state lost");
endmodule

bind dos_top dos_top_sva i_dos_top_sva (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .run_i, .motor_current_i, .voltage_input_one_i,
    .analog_v2_i, .analog_i1_i, .relay_o, .oc_out_o, .freq_zero_o, .start_dc_dwell_inhibit_o);

//--- tb/tb.sv
`include "dos_consts.vh"
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; \
    $display("unexpected %s expected %0h seen %0h", n, e, g); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    reg         clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    reg  [7:0]  wb_adr_i = 8'h00;
    reg  [3:0]  wb_sel_i = 4'h0;
    reg  [31:0] wb_dat_i = 32'h00000000;
    reg  [6:0]  timer_in_i = 7'h00, timer_in_en_i = 7'h00;
    reg         run_i = 1'b0, reverse_i = 1'b0;
    reg  [15:0] motor_current_i = 16'h0000, voltage_input_one_i = 16'h0000;
    reg  [15:0] analog_v2_i = 16'h0000, analog_i1_i = 16'h0000;
    wire [31:0] wb_dat_o;
    wire [15:0] out_freq_i, freq_target_o;
    wire        wb_ack_o, relay_o, oc_out_o, freq_ramp_o, freq_hold_o, freq_zero_o;
    wire        dc_brake_o, output_cut_o, start_dc_dwell_inhibit_o;
    int         err_total = 0, n_compared = 0, cycles = 0;
    dos_top i_dos_top (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .timer_in_i, .timer_in_en_i, .run_i, .reverse_i,
        .motor_current_i, .out_freq_i, .voltage_input_one_i, .analog_v2_i, .analog_i1_i, .relay_o,
        .oc_out_o, .freq_ramp_o, .freq_hold_o, .freq_zero_o, .freq_target_o, .dc_brake_o,
        .output_cut_o, .start_dc_dwell_inhibit_o);
    dos_plant i_dos_plant (.clk_i(clk_i), .ramp_i(freq_ramp_o), .hold_i(freq_hold_o),
        .zero_i(freq_zero_o), .target_i(freq_target_o), .freq_o(out_freq_i));
    initial forever #2.5 clk_i = ~clk_i;
    // ****************************************************************
    // bus and reset helpers
    // ****************************************************************
    task automatic wb_io(input [7:0] a, input w, input [3:0] s, input [31:0] dt,
                         output [31:0] q);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= dt;
        // waits for ack; only the bench timeout ends it if ack never comes
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic wr(input [7:0] a, input [15:0] dt);
        reg [31:0] q;
        wb_io(a, 1'b1, 4'hF, {16'h0000, dt}, q);
    endtask
    task automatic rd(input [7:0] a, output [31:0] q);
        wb_io(a, 1'b0, 4'hF, 32'h00000000, q);
    endtask
    task automatic do_reset();
        rst_i <= 1'b1;
        run_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
    endtask
    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_defaults();
        reg [31:0] q;
        reg [15:0] dv [0:10] = '{16'h012C, 16'h0064, 16'h1388, 16'h0064, 16'h0064, 16'h0064,
                                 16'h0064, 16'h00C8, 16'h0001, 16'h2328, 16'h03E8};
        `CHK("idle outputs", 6'h08, {relay_o, oc_out_o, freq_zero_o, freq_ramp_o, dc_brake_o,
             output_cut_o})
        for (int i = 0; i < 11; i++) begin
            rd(8'h04 + 8'(4 * i), q);
            `CHK("default", {16'h0000, dv[i]}, q)
        end
        rd(8'h3C, q);
        `CHK("unmapped", 32'h00000000, q)
    endtask
    task automatic t_clamp();
        reg [31:0] q;
        wr(8'h28, 16'h0100);
        rd(8'h28, q);
        `CHK("on clamp", 32'h000003E8, q)
        wr(8'h28, 16'h2328);
        wr(8'h2C, 16'h2710);
        rd(8'h2C, q);
        `CHK("off clamp", 32'h00002328, q)
        wr(8'h2C, 16'h03E8);
        wb_io(8'h04, 1'b1, 4'h1, 32'h00000005, q);
        rd(8'h04, q);
        `CHK("narrow write", 32'h0000012C, q)
    endtask
    // other inputs get the mirror value so a wrong source shows
    task automatic t_onoff();
        reg [15:0] v [0:3] = '{16'h251C, 16'h1388, 16'h01F4, 16'h1388};
        reg        ex [0:3] = '{1'b1, 1'b1, 1'b0, 1'b0};
        wr(8'h00, 16'h000C);
        for (int s = 1; s < 4; s++) begin
            wr(8'h24, 16'(s));
            for (int k = 0; k < 4; k++) begin
                voltage_input_one_i <= s == 1 ? v[k] : 16'h2710 - v[k];
                analog_v2_i <= s == 2 ? v[k] : 16'h2710 - v[k];
                analog_i1_i <= s == 3 ? v[k] : 16'h2710 - v[k];
                repeat (4) @(posedge clk_i);
                `CHK("onoff", ex[k], oc_out_o)
            end
        end
    endtask
    task automatic t_timer();
        do_reset();
        wr(8'h00, 16'h0001);
        timer_in_en_i <= 7'h04;
        timer_in_i <= 7'h04;
        repeat (100) @(posedge clk_i);
        `CHK("timer early", 1'b0, relay_o)
        // a zero delay acts without waiting for a 10 ms tick
        wr(8'h04, 16'h0000);
        repeat (4) @(posedge clk_i);
        `CHK("timer on", 1'b1, relay_o)
        wr(8'h08, 16'h0000);
        timer_in_i <= 7'h00;
        repeat (4) @(posedge clk_i);
        `CHK("timer off", 1'b0, relay_o)
    endtask
    task automatic t_brake(input rev, input [15:0] f, input [1:0] m);
        int n;
        do_reset();
        wr(8'h00, {10'h000, m, 4'h2});
        wr(8'h18, 16'h0032);
        motor_current_i <= 16'h0000;
        reverse_i <= rev;
        run_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        `CHK("release target", f, freq_target_o)
        `CHK("start inhibit", 1'b1, start_dc_dwell_inhibit_o)
        for (n = 0; n < 500 && out_freq_i !== f; n++) @(posedge clk_i);
        repeat (8) @(posedge clk_i);
        `CHK("brake early", m != 2'h0, relay_o)
        motor_current_i <= 16'h1770;
        for (n = 0; n < 20 && relay_o !== 1'b1; n++) @(posedge clk_i);
        `CHK("brake open", 1'b1, relay_o)
        `CHK("release hold", 1'b1, freq_hold_o)
    endtask
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // a run needs well under a thousand cycles; far beyond that means a hang
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 30000) begin
            err_total++;
            test_done();
        end
    end
    initial begin
        do_reset();
        t_defaults();
        t_clamp();
        t_onoff();
        t_timer();
        t_brake(1'b0, 16'h0064, 2'h0);
        t_brake(1'b1, 16'h0032, 2'h0);
        t_brake(1'b0, 16'h0064, 2'h1);
        test_done();
    end
endmodule
